// ===== hw/ncr_regs.sv
// node configuration register and buffer ram address pointer, wishbone slave
// Summary of operation
// - bit7 selects sixteen-bit bus, else eight-bit
// - bit6 enables chained commands
// - io mapped: bit5 picks 8K/16K rom
// - memory mapped: bit5, rom enable pick decode
// - bits4,3 select extended network timeouts
// - bit2 set inserts one wait state on io mapped data port accesses
// - bit2 clear drives zero wait state
// - bit1 selects io mapped buffer access
// - bit0 silences transmitter, receiver stays
// - config resets to 1c on hardware reset
// - pointer low gives ram address 7-0
// - pointer high 2-0 gives address 10-8
// - pointer high 7,5-3 have no function
// - bit6 auto advances pointer in io mode
// - data port accesses pointed buffer location
// - wide mode shows ram as 1Kx16
`timescale 1ns/1ps
`default_nettype none
module ncr_regs #(
   parameter int RAM_DEPTH = 2048
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        CE,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             WB_ERR_O,
   input  wire logic        ROM_ENABLE_INPUT_N,
   output logic             WIDE_BUS_ENABLE,
   output logic             CHAINED_COMMAND_ENABLE,
   output logic [1:0]       EXTENDED_TIMEOUT_SELECT,
   output logic             TX_SILENCE,
   output logic             IO_MAPPED,
   output logic             ROM_16K_SELECT,
   output logic             MEMCS16_2K_SELECT,
   output logic             IOCHRDY,
   output logic             ZERO_WAIT_STATE,
   output logic [10:0]      RAM_ADDRESS
);
   typedef struct packed {
      ncr_pkg::ncr_state_t state;
      logic [7:0]          cfg;
      logic [7:0]          ptr_low;
      logic [7:0]          ptr_high;
      logic [1:0]          wait_cnt;
      logic                ack;
      logic                err;
      logic [31:0]         rdata;
   } ncr_regs_t;

   ncr_regs_t cur;
   ncr_regs_t next_cur;
   logic [7:0] ram [RAM_DEPTH];
   logic [7:0] ram_rd;

   // pointer advance: byte step in narrow mode, word step in wide mode, wrap at top
   function automatic logic [10:0] ncr_advance(input logic [10:0] p, input logic wide);
      logic [10:0] step;
      step = wide ? 11'h002 : 11'h001;
      return p + step;
   endfunction : ncr_advance

   logic        req;
   logic        wait_on;
   logic [10:0] ptr;
   logic        data_hit;
   assign req      = WB_CYC_I && WB_STB_I && !cur.ack && !cur.err;
   assign wait_on  = cur.cfg[ncr_pkg::CFG_WAIT];
   assign ptr      = {cur.ptr_high[2:0], cur.ptr_low};
   assign data_hit = WB_ADR_I == ncr_pkg::ADDR_DATA;

   always_comb begin
      next_cur     = cur;
      next_cur.ack = 1'b0;
      next_cur.err = 1'b0;
      unique case (cur.state)
         ncr_pkg::NCR_IDLE: begin
            if (req) begin
               if (wait_on && data_hit && cur.cfg[ncr_pkg::CFG_IO]) begin
                  next_cur.state    = ncr_pkg::NCR_WAIT;
                  next_cur.wait_cnt = ncr_pkg::WAIT_CYCLES;
               end else begin
                  next_cur.state = ncr_pkg::NCR_ACK;
               end
            end
         end
         ncr_pkg::NCR_WAIT: begin
            if (cur.wait_cnt == 2'h1) begin
               next_cur.state = ncr_pkg::NCR_ACK;
            end else begin
               next_cur.wait_cnt = cur.wait_cnt - 2'h1;
            end
         end
         ncr_pkg::NCR_ACK: begin
            next_cur.state = ncr_pkg::NCR_IDLE;
            next_cur.rdata = 32'h0000_0000;
            unique case (WB_ADR_I)
               ncr_pkg::ADDR_CONFIG: begin
                  next_cur.rdata[7:0] = cur.cfg;
                  if (WB_WE_I && WB_SEL_I[0]) begin
                     next_cur.cfg = WB_DAT_I[7:0];
                  end
               end
               ncr_pkg::ADDR_PTR_LOW: begin
                  next_cur.rdata[7:0] = cur.ptr_low;
                  if (WB_WE_I && WB_SEL_I[0]) begin
                     next_cur.ptr_low = WB_DAT_I[7:0];
                  end
               end
               ncr_pkg::ADDR_PTR_HIGH: begin
                  next_cur.rdata[7:0] = cur.ptr_high & ncr_pkg::PH_MASK;
                  if (WB_WE_I && WB_SEL_I[0]) begin
                     next_cur.ptr_high = WB_DAT_I[7:0] & ncr_pkg::PH_MASK;
                  end
               end
               ncr_pkg::ADDR_DATA: begin
                  // only meaningful in io mapped mode; otherwise an error answer
                  if (cur.cfg[ncr_pkg::CFG_IO]) begin
                     next_cur.rdata[7:0] = ram_rd;
                     if (cur.cfg[ncr_pkg::CFG_WIDE]) begin
                        next_cur.rdata[15:8] = ram[{ptr[10:1], 1'b1}];
                     end
                     if (cur.ptr_high[ncr_pkg::PH_AUTO]) begin
                        {next_cur.ptr_high[2:0], next_cur.ptr_low} =
                           ncr_advance(ptr, cur.cfg[ncr_pkg::CFG_WIDE]);
                     end
                  end else begin
                     next_cur.err = 1'b1;
                  end
               end
               default: begin
                  next_cur.err = 1'b1;
               end
            endcase
            next_cur.ack = !next_cur.err;
         end
         default: begin
            next_cur.state = ncr_pkg::NCR_IDLE;
         end
      endcase
   end

   // in wide mode the word is aligned: low byte at even address
   logic [10:0] wr_lo;
   assign wr_lo  = cur.cfg[ncr_pkg::CFG_WIDE] ? {ptr[10:1], 1'b0} : ptr;
   assign ram_rd = ram[wr_lo];

   always_ff @(posedge CLK) begin
      if (CE && cur.state == ncr_pkg::NCR_ACK && WB_WE_I && data_hit && cur.cfg[ncr_pkg::CFG_IO]) begin
         if (WB_SEL_I[0]) begin
            ram[wr_lo] <= WB_DAT_I[7:0];
         end
         if (cur.cfg[ncr_pkg::CFG_WIDE] && WB_SEL_I[1]) begin
            ram[{ptr[10:1], 1'b1}] <= WB_DAT_I[15:8];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         cur          <= '0;
         cur.state    <= ncr_pkg::NCR_IDLE;
         cur.cfg      <= ncr_pkg::CFG_RESET;
      end else if (CE) begin
         cur <= next_cur;
      end
   end

   assign WB_DAT_O                = cur.rdata;
   assign WB_ACK_O                = cur.ack;
   assign WB_ERR_O                = cur.err;
   assign WIDE_BUS_ENABLE         = cur.cfg[ncr_pkg::CFG_WIDE];
   assign CHAINED_COMMAND_ENABLE  = cur.cfg[ncr_pkg::CFG_CHAIN];
   assign EXTENDED_TIMEOUT_SELECT = cur.cfg[ncr_pkg::CFG_ET_HI:ncr_pkg::CFG_ET_LO];
   assign TX_SILENCE              = cur.cfg[ncr_pkg::CFG_TX_SILENCE];
   assign IO_MAPPED               = cur.cfg[ncr_pkg::CFG_IO];
   assign ROM_16K_SELECT          = cur.cfg[ncr_pkg::CFG_IO] && cur.cfg[ncr_pkg::CFG_DECODE];
   // 2K decode only when rom is enabled; otherwise the wide 128K decode stays
   assign MEMCS16_2K_SELECT       = !cur.cfg[ncr_pkg::CFG_IO] && cur.cfg[ncr_pkg::CFG_DECODE]
                                    && !ROM_ENABLE_INPUT_N;
   assign IOCHRDY                 = cur.state != ncr_pkg::NCR_WAIT;
   assign ZERO_WAIT_STATE         = !wait_on;
   assign RAM_ADDRESS             = ptr;

   // configuration register: reset value, writes and holding
   a_cfg_reset: assert property (@(posedge CLK)
      !RSTN |=> cur.cfg == ncr_pkg::CFG_RESET)
      else $error("configuration not at reset value");
   a_cfg_write: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && cur.state == ncr_pkg::NCR_ACK && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ncr_pkg::ADDR_CONFIG
      |=> cur.cfg == $past(WB_DAT_I[7:0]))
      else $error("configuration write lost");
   a_cfg_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && !(cur.state == ncr_pkg::NCR_ACK && WB_WE_I && WB_ADR_I == ncr_pkg::ADDR_CONFIG) |=> $stable(cur.cfg))
      else $error("configuration changed without a write");

   // mode outputs follow the register fields
   a_wide_out: assert property (@(posedge CLK) disable iff (!RSTN)
      WIDE_BUS_ENABLE == cur.cfg[ncr_pkg::CFG_WIDE])
      else $error("wide bus output wrong");
   a_chain_out: assert property (@(posedge CLK) disable iff (!RSTN)
      CHAINED_COMMAND_ENABLE == cur.cfg[ncr_pkg::CFG_CHAIN])
      else $error("chain output wrong");
   a_rom_size: assert property (@(posedge CLK) disable iff (!RSTN)
      ROM_16K_SELECT == (cur.cfg[ncr_pkg::CFG_IO] && cur.cfg[ncr_pkg::CFG_DECODE]))
      else $error("rom size select wrong");
   a_memcs_dec: assert property (@(posedge CLK) disable iff (!RSTN)
      MEMCS16_2K_SELECT |-> !cur.cfg[ncr_pkg::CFG_IO])
      else $error("memcs decode in io mode");
   a_memcs_rom: assert property (@(posedge CLK) disable iff (!RSTN)
      ROM_ENABLE_INPUT_N |-> !MEMCS16_2K_SELECT)
      else $error("memcs small decode without rom");
   a_timeout_sel: assert property (@(posedge CLK) disable iff (!RSTN)
      EXTENDED_TIMEOUT_SELECT == cur.cfg[ncr_pkg::CFG_ET_HI:ncr_pkg::CFG_ET_LO])
      else $error("timeout select wrong");
   a_io_out: assert property (@(posedge CLK) disable iff (!RSTN)
      IO_MAPPED == cur.cfg[ncr_pkg::CFG_IO])
      else $error("io mapped output wrong");
   a_tx_silence_out: assert property (@(posedge CLK) disable iff (!RSTN)
      TX_SILENCE == cur.cfg[ncr_pkg::CFG_TX_SILENCE])
      else $error("tx silence wrong");
   a_zws_out: assert property (@(posedge CLK) disable iff (!RSTN)
      ZERO_WAIT_STATE != cur.cfg[ncr_pkg::CFG_WAIT])
      else $error("zero wait state output wrong");

   // wait state: entered only for io data port accesses, left after its count
   sequence s_wait_start;
      cur.state == ncr_pkg::NCR_IDLE && req && wait_on && data_hit && cur.cfg[ncr_pkg::CFG_IO] && CE;
   endsequence
   sequence s_wait_end;
      cur.state == ncr_pkg::NCR_WAIT && cur.wait_cnt == 2'h1 && CE;
   endsequence
   a_one_wait: assert property (@(posedge CLK) disable iff (!RSTN)
      s_wait_start |=> !IOCHRDY)
      else $error("wait state missing");
   a_wait_ends: assert property (@(posedge CLK) disable iff (!RSTN)
      s_wait_end |=> IOCHRDY)
      else $error("wait state too long");
   a_wait_cause: assert property (@(posedge CLK) disable iff (!RSTN)
      !IOCHRDY |-> wait_on && cur.cfg[ncr_pkg::CFG_IO])
      else $error("wait state without cause");
   a_zero_wait: assert property (@(posedge CLK) disable iff (!RSTN)
      !wait_on |-> IOCHRDY && ZERO_WAIT_STATE)
      else $error("zero wait state wrong");

   // bus answers are single pulses and never both at once
   a_ack_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
      WB_ACK_O && CE |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_err_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
      WB_ERR_O && CE |=> !WB_ERR_O)
      else $error("err longer than one cycle");
   a_ack_excl: assert property (@(posedge CLK) disable iff (!RSTN)
      !(WB_ACK_O && WB_ERR_O))
      else $error("ack and err together");
   a_data_err: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && cur.state == ncr_pkg::NCR_ACK && data_hit && !cur.cfg[ncr_pkg::CFG_IO] |=> WB_ERR_O)
      else $error("data port open in memory mode");
   a_rdata_top: assert property (@(posedge CLK) disable iff (!RSTN)
      WB_DAT_O[31:16] == 16'h0000)
      else $error("read data above a word");

   // pointer: address bits, unused bits, advance and hold
   a_ptr_low: assert property (@(posedge CLK) disable iff (!RSTN)
      RAM_ADDRESS[7:0] == cur.ptr_low)
      else $error("low address bits wrong");
   a_ptr_high: assert property (@(posedge CLK) disable iff (!RSTN)
      RAM_ADDRESS[10:8] == cur.ptr_high[2:0])
      else $error("high address bits wrong");
   a_ph_unused: assert property (@(posedge CLK) disable iff (!RSTN)
      (cur.ptr_high & ~ncr_pkg::PH_MASK) == 8'h00)
      else $error("unused pointer bits set");
   a_ph_read: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && cur.state == ncr_pkg::NCR_ACK && WB_ADR_I == ncr_pkg::ADDR_PTR_HIGH
      |=> (WB_DAT_O[7:0] & ~ncr_pkg::PH_MASK) == 8'h00)
      else $error("unused pointer bits read back");
   sequence s_auto_byte;
      CE && cur.state == ncr_pkg::NCR_ACK && data_hit && cur.cfg[ncr_pkg::CFG_IO]
         && cur.ptr_high[ncr_pkg::PH_AUTO] && !cur.cfg[ncr_pkg::CFG_WIDE];
   endsequence
   sequence s_auto_word;
      CE && cur.state == ncr_pkg::NCR_ACK && data_hit && cur.cfg[ncr_pkg::CFG_IO]
         && cur.ptr_high[ncr_pkg::PH_AUTO] && cur.cfg[ncr_pkg::CFG_WIDE];
   endsequence
   a_auto_inc: assert property (@(posedge CLK) disable iff (!RSTN)
      s_auto_byte |=> RAM_ADDRESS == $past(RAM_ADDRESS) + 11'h001)
      else $error("pointer did not advance");
   a_word_step: assert property (@(posedge CLK) disable iff (!RSTN)
      s_auto_word |=> RAM_ADDRESS == $past(RAM_ADDRESS) + 11'h002)
      else $error("pointer did not step a word");
   a_no_auto: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && cur.state == ncr_pkg::NCR_ACK && data_hit && !cur.ptr_high[ncr_pkg::PH_AUTO] |=> $stable(RAM_ADDRESS))
      else $error("pointer moved without auto advance");
   a_ptr_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      CE && cur.state != ncr_pkg::NCR_ACK |=> $stable(RAM_ADDRESS))
      else $error("pointer moved outside an access");
endmodule : ncr_regs
`default_nettype wire

// ===== inc/ncr_pkg.sv
// package: register map, field positions and reset values of the node configuration block
package ncr_pkg;
   // wishbone byte addresses (word aligned)
   localparam logic [3:0] ADDR_CONFIG   = 4'h0;
   localparam logic [3:0] ADDR_PTR_LOW  = 4'h4;
   localparam logic [3:0] ADDR_PTR_HIGH = 4'h8;
   localparam logic [3:0] ADDR_DATA     = 4'hc;
   // configuration field positions
   localparam int CFG_WIDE    = 7;
   localparam int CFG_CHAIN   = 6;
   localparam int CFG_DECODE  = 5;
   localparam int CFG_ET_HI   = 4;
   localparam int CFG_ET_LO   = 3;
   localparam int CFG_WAIT    = 2;
   localparam int CFG_IO      = 1;
   localparam int CFG_TX_SILENCE   = 0;
   localparam logic [7:0] CFG_RESET = 8'h1c;
   // pointer high fields
   localparam int PH_AUTO = 6;
   localparam logic [7:0] PH_MASK = 8'h47;
   localparam int PTR_W = 11;
   // one wait state lasts this many crystal periods
   localparam logic [1:0] WAIT_CYCLES = 2'h1;
   typedef enum logic [2:0] {
      NCR_IDLE = 3'b001,
      NCR_WAIT = 3'b010,
      NCR_ACK  = 3'b100
   } ncr_state_t;
endpackage : ncr_pkg

// ===== verif/ncr_host.sv
// host processor model: classic wishbone master on the register bus
`timescale 1ns/1ps
`default_nettype none
module ncr_host (
   input  wire logic        CLK,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [3:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic [31:0] rdat,
   input  wire logic        ack,
   input  wire logic        err
);
   initial begin
      {cyc, stb, we, adr, sel, dat} = '0;
   end
   // called just after a rising edge; lat counts edges up to the answer
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e, output int lat);
      lat = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'h3;
      dat <= d;
      do begin
         @(posedge CLK);
         lat++;
      end while (ack !== 1'b1 && err !== 1'b1);
      q = rdat;
      e = err;
      {cyc, stb} <= 2'b00;
      // released write data must not keep showing the last value
      dat <= ~d;
      @(posedge CLK);
   endtask : xfer
endmodule : ncr_host
`default_nettype wire

// ===== verif/ncr_regs_tb.sv
// self-checking bench for the node configuration and ram pointer registers
`timescale 1ns/1ps
`default_nettype none
module ncr_regs_tb;
   logic        clk, rstn, rom_n, cyc, stb, we, ack, err, e;
   logic        wide, chain, tx, io, r16, m2k, rdy, zws;
   logic [1:0]  et;
   logic [3:0]  adr, sel;
   logic [7:0]  v;
   logic [10:0] ra;
   logic [31:0] wdat, rdat, q;
   int          errors, n_tests, lat, lo_base;
   int          lo_cnt = 0;

   ncr_host host (.CLK(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
      .rdat(rdat), .ack(ack), .err(err));
   ncr_regs dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
      .ROM_ENABLE_INPUT_N(rom_n), .WIDE_BUS_ENABLE(wide), .CHAINED_COMMAND_ENABLE(chain),
      .EXTENDED_TIMEOUT_SELECT(et), .TX_SILENCE(tx), .IO_MAPPED(io), .ROM_16K_SELECT(r16),
      .MEMCS16_2K_SELECT(m2k), .IOCHRDY(rdy), .ZERO_WAIT_STATE(zws), .RAM_ADDRESS(ra));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (rdy === 1'b0) lo_cnt <= lo_cnt + 1;

   task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, ex, got);
      end
   endtask : chk
   task rw(input logic w, input logic [3:0] a, input logic [31:0] d);
      host.xfer(w, a, d, q, e, lat);
   endtask : rw
   task outs(input logic [7:0] c);
      chk("outs", {c[7], c[6], c[4:3], c[0], c[1], c[1] & c[5], ~c[1] & c[5] & ~rom_n, ~c[2]},
          {wide, chain, et, tx, io, r16, m2k, zws});
   endtask : outs
   // one data port access after loading the configuration
   task dp(input logic [7:0] c, input logic [10:0] ex, input int el);
      rw(1'b1, ncr_pkg::ADDR_CONFIG, {24'h0, c});
      lo_base = lo_cnt;
      rw(1'b1, ncr_pkg::ADDR_DATA, 32'h5a);
      chk("latency", el, lat);
      chk("ram addr", {21'h0, ex}, {21'h0, ra});
      chk("wait seen", {31'h0, c[2] & c[1]}, {31'h0, lo_cnt != lo_base});
   endtask : dp
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   initial begin
      #300000;
      errors++;
      complete_run();
   end

   initial begin
      {rom_n, rstn} = 2'b00;
      errors = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      outs(ncr_pkg::CFG_RESET);
      chk("idle ready", 32'h1, {31'h0, rdy});
      rw(1'b0, ncr_pkg::ADDR_CONFIG, 0);
      chk("cfg reset", 32'h1c, q);
      for (int i = 0; i < 10; i++) begin
         v = (i < 8) ? 8'h01 << i : (i == 8 ? 8'h22 : 8'hff);
         rw(1'b1, ncr_pkg::ADDR_CONFIG, {24'h0, v});
         rw(1'b0, ncr_pkg::ADDR_CONFIG, 0);
         chk("cfg", {24'h0, v}, q);
         outs(v);
         rom_n <= 1'b1;
         @(posedge clk);
         outs(v);
         rom_n <= 1'b0;
      end
      rw(1'b1, ncr_pkg::ADDR_CONFIG, 32'h18);
      chk("same timeouts", 32'h3, {30'h0, et});
      $display("test config done");
      rw(1'b1, ncr_pkg::ADDR_PTR_LOW, 32'hff);
      rw(1'b1, ncr_pkg::ADDR_PTR_HIGH, 32'hff);
      rw(1'b0, ncr_pkg::ADDR_PTR_HIGH, 0);
      chk("ptr high", 32'h47, q);
      chk("ram addr", 32'h7ff, {21'h0, ra});
      dp(8'h02, 11'h000, 3);
      dp(8'h82, 11'h002, 3);
      dp(8'h06, 11'h003, 4);
      rw(1'b1, ncr_pkg::ADDR_PTR_HIGH, 0);
      rw(1'b1, ncr_pkg::ADDR_PTR_LOW, 32'h10);
      dp(8'h02, 11'h010, 3);
      rw(1'b1, ncr_pkg::ADDR_DATA, 32'ha5);
      rw(1'b0, ncr_pkg::ADDR_DATA, 0);
      chk("data", 32'ha5, q);
      $display("test pointer done");
      rw(1'b1, ncr_pkg::ADDR_CONFIG, 0);
      rw(1'b1, ncr_pkg::ADDR_DATA, 32'h11);
      chk("data err", 32'h1, {31'h0, e});
      rw(1'b1, 4'h1, 32'hff);
      chk("unmapped err", 32'h1, {31'h0, e});
      rw(1'b0, ncr_pkg::ADDR_CONFIG, 0);
      chk("cfg kept", 32'h0, q);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rw(1'b0, ncr_pkg::ADDR_CONFIG, 0);
      chk("cfg rereset", 32'h1c, q);
      chk("ptr rereset", 32'h0, {21'h0, ra});
      $display("test refuse and reset done");
      complete_run();
   end
endmodule : ncr_regs_tb
`default_nettype wire
